// >>> include/gyh_defs.svh
// named constants of the gyro startup and health monitor
// assumes a 32-bit apb slave and a 250 MHz pclk
// Notes on behaviour
// - reset low: hold preset, ignore serial commands
// - on release load calibration, then seek resonance
// - range select pins sampled at reset release only, and only in analogue mode
// - all monitors except output saturation gated into one health output
// - calibration parity fault forces health false
// - bad trim dac conversion forces health false
// - agc drive out of limits forces health false
// - health false until loops have settled
// - demodulator saturation fails, output saturation not
// - excessive quadrature magnitude forces health false
// - checksum failure flagged in reply, not health
// - self-test adds 50 deg/s rate offset
// - self-test from pin or serial command bit
// - self-test active drives health false
// - temperature only through digital interface
// - temperature code 2.75 per degree, 600 at 25
// - analogue self-test pin is active low
// - reset latches range selects in analogue mode (range 3 in digital mode), reloads calibration
// - command bit 6 enables or disables self-test
`ifndef GYH_DEFS_SVH
`define GYH_DEFS_SVH
// calibration memory walk
`define GYH_CAL_LAST      4'hF
`define GYH_CAL_FIRST     4'h0
// apb register byte addresses
`define GYH_ADDR_STATUS   12'h000
`define GYH_ADDR_QLIM     12'h004
`define GYH_ADDR_TEMP     12'h008
`define GYH_QLIM_RST      16'h4000
// command byte fields
`define GYH_CMD_FACTORY   7
`define GYH_CMD_SELFTEST  6
`define GYH_CMD_RSRC      5
`define GYH_CMD_RHI       4
`define GYH_CMD_RLO       3
// range codes: 0 = 900, 1 = 300, 2 = 150, 3 = 75 deg/s
`define GYH_RANGE_DEFAULT 2'h3
// self-test offset in deg/s
`define GYH_SELFTEST_DPS  8'h32
// temperature: code = 600 + 11/4 * (t - 25)
`define GYH_TEMP_REF_C    10'sh019
`define GYH_TEMP_SLOPE_X4 14'sh000B
`define GYH_TEMP_SHIFT    2
`define GYH_TEMP_CODE_25C 12'h258
`endif

// >>> include/gyh_pkg.sv
// types of the gyro startup and health monitor
// assumes gyh_defs.svh supplies the numbers
package gyh_pkg;
  // startup sequence, gray coded along the path
  typedef enum logic [1:0] {
    GYH_PRESET = 2'b00,
    GYH_LOAD   = 2'b01,
    GYH_SEARCH = 2'b11,
    GYH_RUN    = 2'b10
  } gyh_phase_t;
  // one serial command message, first byte on top
  typedef struct packed {
    logic [7:0]      cmd;
    logic [3:0][7:0] spare;
    logic [7:0]      csum;
  } gyh_msg_t;
  // analogue monitor results, high means fault except loops_settled
  typedef struct packed {
    logic        agc_high;
    logic        agc_low;
    logic        demod_sat;
    logic        output_sat;
    logic        loops_settled;
    logic [15:0] quad_mag;
  } gyh_mon_t;
  // status register layout
  typedef struct packed {
    logic [13:0] zero;
    logic [1:0]  phase;
    logic [1:0]  range;
    logic        self_test;
    logic        csum_fail;
    logic        quad_fail;
    logic        demod_fail;
    logic        agc_fail;
    logic        dac_fail;
    logic        parity_fail;
    logic        health;
    logic [5:0]  zero_lo;
  } gyh_status_t;
  // all state of the monitor
  typedef struct packed {
    gyh_phase_t  phase;
    logic [3:0]  cal_idx;
    logic        parity_fail;
    logic        dac_fail;
    logic [1:0]  range;
    logic        st_serial;
    logic        self_test;
    logic        csum_fail;
    logic        quad_fail;
    logic        health;
    logic [7:0]  st_offset;
    logic [15:0] qlim;
    logic [11:0] temp_code;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gyh_state_t;
endpackage

// >>> hw/gyh_monitor.sv
// startup sequencer, health gate, self-test and temperature code of the rate sensor
// assumes device pins are synchronous to pclk and software uses a 32-bit apb master
`timescale 1ns/10ps
`default_nettype none
`include "gyh_defs.svh"

module gyh_monitor (
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // device pins
  input  wire logic             device_reset_n,
  input  wire logic             digital_mode,
  input  wire logic             commanded_self_test_n,
  input  wire logic             range_select_0,
  input  wire logic             range_select_1,
  // calibration memory, even parity in bit 8
  output logic      [3:0]       cal_addr,
  input  wire logic [8:0]       cal_word,
  input  wire logic             dac_mismatch,
  // analogue monitors and die temperature in degrees c
  input  wire gyh_pkg::gyh_mon_t mon,
  input  wire logic signed [7:0] die_temp,
  // serial command message after framing
  input  wire logic             msg_valid,
  input  wire gyh_pkg::gyh_msg_t msg,
  // results
  output logic                  health,
  output logic                  csum_fail,
  output logic                  self_test,
  output logic      [7:0]       self_test_offset,
  output logic      [1:0]       rate_range,
  output logic      [11:0]      temp_code
);
  import gyh_pkg::*;

  gyh_state_t  r;
  gyh_state_t  next_r;
  gyh_status_t stat;

  // checksum and temperature arithmetic
  logic [7:0]         byte_sum;
  logic               csum_ok;
  logic signed [9:0]  t_diff;
  logic signed [13:0] t_prod;
  logic [11:0]        t_code;
  logic               apb_access;
  logic               quad_bad;

  // inverse of the byte sum must match the last byte
  always_comb begin
    byte_sum = msg.cmd + msg.spare[3] + msg.spare[2] + msg.spare[1] + msg.spare[0];
    csum_ok  = (~byte_sum) == msg.csum;
  end

  // temperature scaling, slope 11/4 around the 25 degree point
  always_comb begin
    t_diff = {{2{die_temp[7]}}, die_temp} - `GYH_TEMP_REF_C;
    t_prod = 14'(t_diff) * `GYH_TEMP_SLOPE_X4;
    t_code = `GYH_TEMP_CODE_25C + 12'(t_prod >>> `GYH_TEMP_SHIFT);
  end

  // status word seen by software
  always_comb begin
    stat             = '0;
    stat.phase       = r.phase;
    stat.range       = r.range;
    stat.self_test   = r.self_test;
    stat.csum_fail   = r.csum_fail;
    stat.quad_fail   = r.quad_fail;
    stat.demod_fail  = mon.demod_sat;
    stat.agc_fail    = mon.agc_high | mon.agc_low;
    stat.dac_fail    = r.dac_fail;
    stat.parity_fail = r.parity_fail;
    stat.health      = r.health;
  end

  assign apb_access = psel & penable & ~r.pready;
  assign quad_bad   = mon.quad_mag > r.qlim;

  // next state of sequencer, monitors and register file
  always_comb begin
    next_r         = r;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;

    unique case (r.phase)
      // held while the reset pin is low, faults wiped for a fresh check
      GYH_PRESET: begin
        if (device_reset_n) begin
          next_r.phase = GYH_LOAD;
          next_r.cal_idx = `GYH_CAL_FIRST;
          if (digital_mode) begin
            next_r.range = `GYH_RANGE_DEFAULT;
          end else begin
            next_r.range = {range_select_1, range_select_0};
          end
        end
      end
      // walk the calibration words, checking parity and dac conversion
      GYH_LOAD: begin
        if (^cal_word) begin
          next_r.parity_fail = 1'b1;
        end
        if (dac_mismatch) begin
          next_r.dac_fail = 1'b1;
        end
        next_r.cal_idx = r.cal_idx + 4'h1;
        if (r.cal_idx == `GYH_CAL_LAST) begin
          next_r.phase = GYH_SEARCH;
        end
      end
      // wait for resonance and closed loops
      GYH_SEARCH: begin
        if (mon.loops_settled) begin
          next_r.phase = GYH_RUN;
        end
      end
      GYH_RUN: begin
      end
    endcase

    // serial commands only while reset is released
    if (device_reset_n && msg_valid) begin
      next_r.csum_fail = ~csum_ok;
      // range and serial self-test exist only with the serial interface,
      // so a stray message in analogue mode cannot move the latched range
      if (digital_mode && csum_ok && !msg.cmd[`GYH_CMD_FACTORY]) begin
        next_r.st_serial = msg.cmd[`GYH_CMD_SELFTEST];
        if (msg.cmd[`GYH_CMD_RSRC]) begin
          next_r.range = {msg.cmd[`GYH_CMD_RHI], msg.cmd[`GYH_CMD_RLO]};
        end else begin
          next_r.range = `GYH_RANGE_DEFAULT;
        end
      end
    end

    // self-test source follows the interface mode
    if (digital_mode) begin
      next_r.self_test = r.st_serial;
    end else begin
      next_r.self_test = ~commanded_self_test_n;
    end
    next_r.st_offset = next_r.self_test ? `GYH_SELFTEST_DPS : 8'h00;

    // quadrature and temperature sampled every cycle
    next_r.quad_fail = quad_bad;
    next_r.temp_code = t_code;

    // one registered health result, output stage saturation left out
    next_r.health = (r.phase == GYH_RUN)
                  & ~r.parity_fail & ~r.dac_fail
                  & ~mon.agc_high & ~mon.agc_low
                  & ~mon.demod_sat
                  & ~r.quad_fail
                  & ~r.self_test;

    // apb access phase answered on its second cycle
    if (apb_access) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      unique case (paddr)
        `GYH_ADDR_STATUS: begin
          next_r.prdata  = stat;
          next_r.pslverr = pwrite;
        end
        `GYH_ADDR_QLIM: begin
          next_r.prdata = {16'h0000, r.qlim};
        end
        `GYH_ADDR_TEMP: begin
          next_r.prdata  = {20'h0_0000, r.temp_code};
          next_r.pslverr = pwrite;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // a limit write lands at the edge that ends the access, with pready seen,
    // so the quadrature compare never uses a limit the master has not committed
    if (psel && penable && r.pready && pwrite && (paddr == `GYH_ADDR_QLIM)) begin
      next_r.qlim = pwdata[15:0];
    end

    // reset pin low overrides sequencer, calibration faults, serial self-test, checksum flag and health
    if (!device_reset_n) begin
      next_r.phase       = GYH_PRESET;
      next_r.cal_idx     = `GYH_CAL_FIRST;
      next_r.parity_fail = 1'b0;
      next_r.dac_fail    = 1'b0;
      next_r.st_serial   = 1'b0;
      next_r.csum_fail   = 1'b0;
      next_r.health      = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.phase <= GYH_PRESET;
      r.range <= `GYH_RANGE_DEFAULT;
      r.qlim  <= `GYH_QLIM_RST;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign prdata           = r.prdata;
  assign pready           = r.pready;
  assign pslverr          = r.pslverr;
  assign cal_addr         = r.cal_idx;
  assign health           = r.health;
  assign csum_fail        = r.csum_fail;
  assign self_test        = r.self_test;
  assign self_test_offset = r.st_offset;
  assign rate_range       = r.range;
  assign temp_code        = r.temp_code;

endmodule // gyh_monitor
`default_nettype wire

// >>> bench/gyh_chk.sv
// checker of health gating, self-test and message timing
// bound to gyh_monitor, sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "gyh_defs.svh"
module gyh_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic device_reset_n,
  input wire logic digital_mode,
  input wire logic commanded_self_test_n,
  input wire gyh_pkg::gyh_mon_t mon,
  input wire logic msg_valid,
  input wire gyh_pkg::gyh_msg_t msg,
  input wire logic health,
  input wire logic csum_fail,
  input wire logic self_test,
  input wire logic [7:0] self_test_offset
);
  import gyh_pkg::*;
  logic [7:0] sum;
  logic       good;
  // checksum of the five leading bytes
  assign sum = msg.cmd + msg.spare[3] + msg.spare[2] + msg.spare[1] + msg.spare[0];
  assign good = (msg.csum == ~sum);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; !device_reset_n |-> ##2 !health; endproperty
  a_hold: assert property (p_hold) else $error("health up in reset");
  property p_st; self_test |=> !health; endproperty
  a_st: assert property (p_st) else $error("health up in self-test");
  property p_ofs; self_test_offset == (self_test ? `GYH_SELFTEST_DPS : 8'h00); endproperty
  a_ofs: assert property (p_ofs) else $error("bad offset");
  property p_agc; mon.agc_high || mon.agc_low |=> !health; endproperty
  a_agc: assert property (p_agc) else $error("agc fault missed");
  property p_dem; mon.demod_sat |=> !health; endproperty
  a_dem: assert property (p_dem) else $error("demod fault missed");
  property p_quad; mon.quad_mag == 16'hFFFF |-> ##2 !health; endproperty
  a_quad: assert property (p_quad) else $error("quad fault missed");
  property p_up; $rose(health) |-> $past(device_reset_n, 19); endproperty
  a_up: assert property (p_up) else $error("health too early");
  property p_cs; msg_valid && device_reset_n |=> csum_fail == !$past(good); endproperty
  a_cs: assert property (p_cs) else $error("bad checksum flag");
  property p_dig; msg_valid && device_reset_n && digital_mode && good && !msg.cmd[7]
    |-> ##2 self_test == $past(msg.cmd[6], 2); endproperty
  a_dig: assert property (p_dig) else $error("serial self-test wrong");
  c_up: cover property ($rose(health));
  c_st: cover property ($rose(self_test));
  c_cs: cover property ($rose(csum_fail));
endmodule // gyh_chk
bind gyh_monitor gyh_chk gyh_chk_i (.pclk, .presetn, .device_reset_n, .digital_mode,
  .commanded_self_test_n, .mon, .msg_valid, .msg, .health, .csum_fail, .self_test,
  .self_test_offset);
`default_nettype wire

// >>> bench/gyh_host.sv
// host model: framed command messages and calibration memory
// send is a one-cycle request from the bench
`timescale 1ns/10ps
`default_nettype none
module gyh_host (
  input wire logic pclk,
  input wire logic send,
  input wire logic [7:0] cmd,
  input wire logic corrupt,
  input wire logic bad_par,
  input wire logic [3:0] cal_addr,
  output logic [8:0] cal_word,
  output logic msg_valid,
  output gyh_pkg::gyh_msg_t msg
);
  import gyh_pkg::*;
  // calibration word, even parity unless corrupted
  assign cal_word = {^cal_addr ^ bad_par, 4'h0, cal_addr};
  // message with checksum; idle lines toggle
  always_ff @(posedge pclk) begin
    msg_valid <= send;
    msg <= send ? {cmd, {4{8'h11}}, ~(cmd + 8'h44) ^ {7'h00, corrupt}} : ~msg;
  end
endmodule // gyh_host
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench of gyh_monitor
// host model supplies messages and calibration words
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gyh_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, dac_mismatch;
  logic device_reset_n, digital_mode, commanded_self_test_n, range_select_0, range_select_1;
  logic send, corrupt, bad_par, msg_valid, health, csum_fail, self_test;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] paddr, temp_code;
  logic [7:0] cmd, self_test_offset;
  logic [8:0] cal_word;
  logic [3:0] cal_addr;
  logic [1:0] rate_range;
  logic signed [7:0] die_temp;
  gyh_msg_t msg;
  gyh_mon_t mon;
  int err_total, compares, cyc;
  gyh_monitor gyh_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .device_reset_n, .digital_mode, .commanded_self_test_n,
    .range_select_0, .range_select_1, .cal_addr, .cal_word, .dac_mismatch, .mon, .die_temp,
    .msg_valid, .msg, .health, .csum_fail, .self_test, .self_test_offset, .rate_range,
    .temp_code);
  gyh_host gyh_host_i (.pclk, .send, .cmd, .corrupt, .bad_par, .cal_addr, .cal_word,
    .msg_valid, .msg);
  // clock and watchdog
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  task test_done;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("Error %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // apb transfer, holds until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task boot(input logic dm, input logic [1:0] rs);
    device_reset_n <= 0;
    digital_mode <= dm;
    {range_select_1, range_select_0} <= rs;
    mon.loops_settled <= 0;
    tick(3);
    device_reset_n <= 1;
    tick(12);
    chk(health, 0);
    chk(cal_addr, 4'hA);
    mon.loops_settled <= 1;
    tick(12);
  endtask
  task msg_tx(input logic [7:0] c, input logic bad);
    send <= 1;
    cmd <= c;
    corrupt <= bad;
    tick(1);
    send <= 0;
    tick(5);
  endtask
  task t_cal;
    bad_par <= 1;
    boot(0, 2'b01);
    chk(health, 0);
    bad_par <= 0;
    dac_mismatch <= 1;
    boot(0, 2'b01);
    chk(health, 0);
    dac_mismatch <= 0;
    boot(0, 2'b01);
    chk(health, 1);
    range_select_0 <= 0;
    tick(3);
    chk(rate_range, 1);
    $display("calibration and startup done");
  endtask
  task t_faults;
    for (int i = 0; i < 4; i++) begin
      boot(0, 2'b11);
      {mon.agc_high, mon.agc_low, mon.demod_sat, mon.output_sat} <= 4'b1000 >> i;
      tick(4);
      chk(health, i == 3);
      {mon.agc_high, mon.agc_low, mon.demod_sat, mon.output_sat} <= 4'b0000;
    end
    $display("monitor faults done");
  endtask
  task t_regs;
    apb(0, 12'h004, 0);
    chk(q, 32'h0000_4000);
    apb(1, 12'h004, 32'h0000_0010);
    apb(0, 12'h004, 0);
    chk(q, 32'h0000_0010);
    apb(0, 12'h00C, 0);
    chk(e, 1);
    chk(q, 32'h0000_0000);
    apb(1, 12'h000, 32'hFFFF_FFFF);
    chk(e, 1);
    apb(0, 12'h008, 0);
    chk(q, 32'h0000_0258);
    die_temp <= 29;
    tick(4);
    chk(temp_code, 12'h263);
    mon.quad_mag <= 16'hFFFF;
    tick(4);
    chk(health, 0);
    mon.quad_mag <= 16'h0000;
    $display("registers done");
  endtask
  task t_self;
    boot(0, 2'b11);
    commanded_self_test_n <= 0;
    tick(3);
    chk(self_test_offset, 8'h32);
    chk(health, 0);
    commanded_self_test_n <= 1;
    tick(3);
    chk(self_test, 0);
    $display("analogue self-test done");
  endtask
  task t_dig;
    boot(1, 2'b00);
    device_reset_n <= 0;
    msg_tx(8'h70, 0);
    chk(self_test, 0);
    boot(1, 2'b00);
    chk(rate_range, 3);
    msg_tx(8'h70, 0);
    chk({self_test, rate_range, csum_fail, health}, 5'b11000);
    msg_tx(8'h20, 0);
    chk({self_test, rate_range, health}, 4'b0001);
    msg_tx(8'h60, 1);
    chk({self_test, csum_fail, health}, 3'b011);
    msg_tx(8'hC0, 0);
    chk({self_test, rate_range, csum_fail}, 4'b0000);
    msg_tx(8'h08, 0);
    chk(rate_range, 3);
    commanded_self_test_n <= 0;
    tick(3);
    chk(self_test, 0);
    commanded_self_test_n <= 1;
    $display("serial commands done");
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd, send, corrupt, bad_par} = '0;
    {dac_mismatch, device_reset_n, digital_mode, range_select_0, range_select_1} = '0;
    commanded_self_test_n = 1;
    mon = '0;
    die_temp = 25;
    presetn = 0;
    tick(2);
    presetn <= 1;
    t_cal;
    t_faults;
    t_regs;
    t_self;
    t_dig;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
